/* include/fcl_pkg.sv */
// Shared constants and types of the fabric configuration loader.
// Assumes a single 125 MHz system clock domain.
package fcl_pkg;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned WORD_W = 32;
   localparam int unsigned BYTES_PER_WORD = WORD_W / BYTE_W;
   localparam logic [31:0] START_KEY = 32'hbcbcbcbc;
   localparam logic [31:0] END_KEY = 32'hbcbcbc00;
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned PROG_PULSE_NS = 500;
   localparam int unsigned PROG_PULSE_CYC =
      (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLDOFF_CYC = 4;
   localparam int unsigned CNT_W = 8;
   typedef enum logic [2:0] {
      ST_AWAIT_KEYWORD = 3'b001,
      ST_CONFIG = 3'b010,
      ST_IDLE = 3'b100
   } fcl_state_e;
   localparam fcl_state_e RST_STATE = ST_AWAIT_KEYWORD;
   localparam logic RST_STRB_N = 1'b1;
   localparam logic RST_PROG_N = 1'b0;
   localparam logic RST_OWN = 1'b1;
endpackage

/* include/fcl_byte_if.sv */
// Byte stream between the comm-port receiver and the word packer.
// Assumes the top module drives ce and clr.
`timescale 1ns/100ps
interface fcl_byte_if #(parameter int unsigned W = fcl_pkg::BYTE_W);
   logic ce;
   logic clr;
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (input ce, input clr, input ready, output valid, output data);
   modport snk (input ce, input clr, input valid, input data, output ready);
endinterface

/* hw/fcl_port_rx.sv */
// Receive side of the byte-wide comm-port handshake.
// Assumes the host holds data stable from before strobe until ready.
`timescale 1ns/100ps
module fcl_port_rx (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control
   input wire logic en_i,
   // Comm-port pins
   input wire logic [fcl_pkg::BYTE_W-1:0] cp_data_i,
   input wire logic cp_strb_n_i,
   output logic cp_rdy_n_o,
   // Byte stream
   fcl_byte_if.src byte_o
);
   import fcl_pkg::*;
   logic [1:0] strb_sync;
   logic [1:0] next_strb_sync;
   logic [BYTE_W-1:0] data_s1, data_s2;
   logic [BYTE_W-1:0] next_data_s1, next_data_s2;
   logic ack, next_ack;
   logic strobe_on;

   assign strobe_on = ~strb_sync[1];
   assign byte_o.valid = en_i & ~ack & strobe_on & ~byte_o.clr;
   assign byte_o.data = data_s2;
   assign cp_rdy_n_o = ~ack;

   always_comb begin
      next_strb_sync = {strb_sync[0], cp_strb_n_i};
      next_data_s1 = cp_data_i;
      next_data_s2 = data_s1;
      next_ack = ack;
      if (byte_o.valid && byte_o.ready) begin
         next_ack = 1'b1;
      end else if (ack && !strobe_on) begin
         next_ack = 1'b0;
      end
      if (byte_o.clr || !en_i) begin
         next_ack = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         strb_sync <= {2{RST_STRB_N}};
         data_s1 <= '0;
         data_s2 <= '0;
         ack <= 1'b0;
      end else if (byte_o.ce) begin
         strb_sync <= next_strb_sync;
         data_s1 <= next_data_s1;
         data_s2 <= next_data_s2;
         ack <= next_ack;
      end
   end

   a_ack_held: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      byte_o.ce && ack && strobe_on && en_i && !byte_o.clr |=> ack)
      else $error("ready dropped while strobe still active");
   a_byte_acked: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      byte_o.ce && byte_o.valid && byte_o.ready |=> ack && !byte_o.valid)
      else $error("taken byte not acknowledged");
endmodule // fcl_port_rx

/* hw/fcl_word_pack.sv */
// Packs consecutive bytes into words, first byte in the low lane.
// Assumes the consumer drains a word with word_ready_i.
`timescale 1ns/100ps
module fcl_word_pack #(
   parameter int unsigned BYTE_W = fcl_pkg::BYTE_W,
   parameter int unsigned WORD_W = fcl_pkg::WORD_W
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Byte stream
   fcl_byte_if.snk byte_i,
   // Word stream
   output logic [WORD_W-1:0] word_o,
   output logic word_valid_o,
   input wire logic word_ready_i
);
   import fcl_pkg::*;
   localparam int unsigned NB = WORD_W / BYTE_W;
   localparam int unsigned CW = (NB > 1) ? $clog2(NB) : 1;
   localparam logic [CW-1:0] LAST = CW'(NB - 1);
   logic [CW-1:0] cnt, next_cnt;
   logic [WORD_W-1:0] acc, next_acc, next_word;
   logic next_valid;

   assign byte_i.ready = ~word_valid_o;

   always_comb begin
      next_cnt = cnt;
      next_acc = acc;
      next_word = word_o;
      next_valid = word_valid_o & ~word_ready_i;
      if (byte_i.valid && byte_i.ready) begin
         next_acc[cnt*BYTE_W +: BYTE_W] = byte_i.data;
         if (cnt == LAST) begin
            next_word = next_acc;
            next_valid = 1'b1;
            next_cnt = '0;
         end else begin
            next_cnt = cnt + CW'(1);
         end
      end
      if (byte_i.clr) begin
         next_cnt = '0;
         next_valid = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= '0;
         acc <= '0;
         word_o <= '0;
         word_valid_o <= 1'b0;
      end else if (byte_i.ce) begin
         cnt <= next_cnt;
         acc <= next_acc;
         word_o <= next_word;
         word_valid_o <= next_valid;
      end
   end

   a_word_stable: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      byte_i.ce && word_valid_o && !word_ready_i && !byte_i.clr
      |=> word_valid_o && $stable(word_o))
      else $error("pending word changed before it was taken");
endmodule // fcl_word_pack

/* hw/fcl_loader.sv */
// Fabric configuration loader: comm-port bitstream to fabric config port.
// Assumes the fabric config port and cfg_ready_i share clk_i; all other
// inputs except arst_n_i and ce_i are pins and are synchronised here.
//
// Functional notes
// - After power-up, poll the port; act only on start keyword bcbcbcbc or end word bcbcbc00.
// - After the start keyword, load following words into the fabric.
// - Fabric done lights the configuration indicator, then the design runs.
// - Fabric reset is open, active low; either side may pull it.
// - Hold fabric reset low through loading until the end word bcbcbc00.
// - After end word idle until module reset or design pulls fabric reset.
// - A design using port 3 stays in reset until download ends.
// - A design ignoring fabric reset may start early; using it is advised.
// - After configuration release port 3 to the loaded design.
// - While owning port 3, perform its handshake and feed the fabric.
// - Module-wide reset resets controller and the programmable fabric.
// - After module reset own port 3 again and accept a fresh bitstream.
// - End word instead of start after reset: skip load, release, idle.
// - Run-time reconfigure request detection lives in the loaded design.
// - Reference design treats a word with LSB set as reconfigure.
// - Command on another port: design drives port 3 pins high.
// - Design pulls fabric reset low, enters reset, frees port 3.
// - Seeing fabric reset low from the design, await a keyword again.
// - Awaiting after interrupt: end word idles, start word reloads.
`timescale 1ns/100ps
module fcl_loader #(
   parameter int unsigned PROG_CYC = fcl_pkg::PROG_PULSE_CYC
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // Module-wide reset pin
   input wire logic module_wide_reset_n_i,
   // Comm port 3
   input wire logic [fcl_pkg::BYTE_W-1:0] cp_data_i,
   input wire logic cp_strb_n_i,
   output logic cp_rdy_n_o,
   output logic cp_rdy_oe_n_o,
   output logic port_owned_o,
   // Fabric global reset, open low
   input wire logic fabric_reset_n_i,
   output logic fabric_reset_n_o,
   output logic fabric_reset_oe_n_o,
   // Fabric configuration port
   output logic cfg_prog_n_o,
   output logic [fcl_pkg::WORD_W-1:0] cfg_data_o,
   output logic cfg_valid_o,
   input wire logic cfg_ready_i,
   input wire logic cfg_done_i,
   // Indicator
   output logic config_indicator_led_o
);
   import fcl_pkg::*;

   fcl_state_e state, next_state;
   logic [CNT_W-1:0] prog_cnt, next_prog_cnt;
   logic [CNT_W-1:0] hold_cnt, next_hold_cnt;
   logic [WORD_W-1:0] next_cfg_data;
   logic next_cfg_valid;
   logic next_prog_n;
   logic own, next_own;
   logic fab_drv, next_fab_drv;
   logic next_led;

   // Pin synchronisers: stage 0 feeds stage 1 only
   logic [1:0] mrst_sync, next_mrst_sync;
   logic [1:0] frst_sync, next_frst_sync;
   logic [1:0] done_sync, next_done_sync;
   logic modrst_s;
   logic fab_rst_low_s;
   logic done_s;

   logic [WORD_W-1:0] word;
   logic word_valid;
   logic word_ready;
   logic word_take;

   fcl_byte_if #(.W(BYTE_W)) byte_bus ();

   assign modrst_s = ~mrst_sync[1];
   assign fab_rst_low_s = ~frst_sync[1];
   assign done_s = done_sync[1];

   assign byte_bus.ce = ce_i;
   assign byte_bus.clr = modrst_s;

   fcl_port_rx u_rx (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .en_i(own & ~modrst_s),
      .cp_data_i(cp_data_i),
      .cp_strb_n_i(cp_strb_n_i),
      .cp_rdy_n_o(cp_rdy_n_o),
      .byte_o(byte_bus)
   );

   fcl_word_pack #(
      .BYTE_W(BYTE_W),
      .WORD_W(WORD_W)
   ) u_pack (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .byte_i(byte_bus),
      .word_o(word),
      .word_valid_o(word_valid),
      .word_ready_i(word_ready)
   );

   // Pins handed to the loaded design once it owns the port
   assign cp_rdy_oe_n_o = ~own;
   assign port_owned_o = own;
   // Only ever pull low; the design may do the same
   assign fabric_reset_n_o = 1'b0;
   assign fabric_reset_oe_n_o = ~fab_drv;

   always_comb begin
      next_mrst_sync = {mrst_sync[0], module_wide_reset_n_i};
      next_frst_sync = {frst_sync[0], fabric_reset_n_i};
      next_done_sync = {done_sync[0], cfg_done_i};
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mrst_sync <= 2'h3;
         frst_sync <= 2'h3;
         done_sync <= 2'h0;
      end else if (ce_i) begin
         mrst_sync <= next_mrst_sync;
         frst_sync <= next_frst_sync;
         done_sync <= next_done_sync;
      end
   end

   // Words are only drawn when they can be acted on, so the host stalls
   // behind the fabric instead of a buffer growing here.
   always_comb begin
      word_ready = 1'b0;
      if (!modrst_s) begin
         unique case (state)
            ST_AWAIT_KEYWORD: word_ready = 1'b1;
            ST_CONFIG: word_ready = (prog_cnt == '0) && !cfg_valid_o;
            ST_IDLE: word_ready = 1'b0;
            default: word_ready = 1'b0;
         endcase
      end
   end

   assign word_take = word_valid & word_ready & ce_i;

   always_comb begin
      next_state = state;
      next_prog_cnt = (prog_cnt != '0) ? prog_cnt - CNT_W'(1) : prog_cnt;
      next_hold_cnt = (hold_cnt != '0) ? hold_cnt - CNT_W'(1) : hold_cnt;
      next_cfg_data = cfg_data_o;
      next_cfg_valid = cfg_valid_o & ~cfg_ready_i;
      unique case (state)
         ST_AWAIT_KEYWORD: begin
            if (word_take && word == START_KEY) begin
               next_state = ST_CONFIG;
               next_prog_cnt = CNT_W'(PROG_CYC);
            end else if (word_take && word == END_KEY) begin
               next_state = ST_IDLE;
               next_hold_cnt = CNT_W'(HOLDOFF_CYC);
            end
            // Any other word is dropped here
         end
         ST_CONFIG: begin
            if (word_take && word == END_KEY) begin
               next_state = ST_IDLE;
               next_hold_cnt = CNT_W'(HOLDOFF_CYC);
            end else if (word_take) begin
               next_cfg_data = word;
               next_cfg_valid = 1'b1;
            end
         end
         ST_IDLE: begin
            // The loaded design decodes its own reconfigure command
            // parks its port 3 pins high when the command came elsewhere
            // and then pulls fabric reset low; that low is all we look for.
            // Holdoff covers our own release still passing the synchroniser
            if (hold_cnt == '0 && fab_rst_low_s) begin
               next_state = ST_AWAIT_KEYWORD;
            end
         end
         default: begin
            next_state = RST_STATE;
         end
      endcase
      if (modrst_s) begin
         next_state = RST_STATE;
         next_prog_cnt = '0;
         next_hold_cnt = '0;
         next_cfg_valid = 1'b0;
      end
      // Fabric is cleared during module reset and before each new load
      next_prog_n = ~(modrst_s || next_prog_cnt != '0);
      next_own = (next_state != ST_IDLE);
      // Design sits in reset for the whole download
      next_fab_drv = (next_state == ST_CONFIG);
      next_led = done_s;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= RST_STATE;
         prog_cnt <= '0;
         hold_cnt <= '0;
         cfg_data_o <= '0;
         cfg_valid_o <= 1'b0;
         cfg_prog_n_o <= RST_PROG_N;
         own <= RST_OWN;
         fab_drv <= 1'b0;
         config_indicator_led_o <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
         prog_cnt <= next_prog_cnt;
         hold_cnt <= next_hold_cnt;
         cfg_data_o <= next_cfg_data;
         cfg_valid_o <= next_cfg_valid;
         cfg_prog_n_o <= next_prog_n;
         own <= next_own;
         fab_drv <= next_fab_drv;
         config_indicator_led_o <= next_led;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!arst_n_i || !ce_i);

   sequence s_awaiting;
      state == ST_AWAIT_KEYWORD && !modrst_s;
   endsequence
   sequence s_loading;
      state == ST_CONFIG && !modrst_s;
   endsequence
   sequence s_start_taken;
      s_awaiting ##0 (word_take && word == START_KEY);
   endsequence
   sequence s_end_taken;
      (state != ST_IDLE && !modrst_s) ##0 (word_take && word == END_KEY);
   endsequence
   sequence s_other_taken;
      s_awaiting ##0 (word_take && word != START_KEY && word != END_KEY);
   endsequence

   a_start_loads: assert property (
      s_start_taken |=> state == ST_CONFIG && !cfg_prog_n_o)
      else $error("start keyword did not begin loading");
   a_wait_ignores: assert property (
      s_other_taken |=> state == ST_AWAIT_KEYWORD && !cfg_valid_o)
      else $error("non-keyword acted on while awaiting");
   a_end_idles: assert property (
      s_end_taken |=> state == ST_IDLE && !own ##1 cp_rdy_oe_n_o)
      else $error("end word did not idle and release the port");
   a_reset_held: assert property (
      s_loading |-> !fabric_reset_oe_n_o && !fabric_reset_n_o)
      else $error("fabric reset not held low while loading");
   a_end_unforwarded: assert property (
      s_loading ##0 (word_take && word == END_KEY) |=> !cfg_valid_o [*2])
      else $error("end word forwarded to the fabric");
   a_word_forward: assert property (
      s_loading ##0 (word_take && word != END_KEY)
      |=> cfg_valid_o && cfg_data_o == $past(word))
      else $error("bitstream word not forwarded");
   a_port_free: assert property (
      state == ST_IDLE |-> !port_owned_o && cp_rdy_oe_n_o && fabric_reset_oe_n_o)
      else $error("port or fabric reset still held in idle");
   a_design_irq: assert property (
      state == ST_IDLE && hold_cnt == '0 && fab_rst_low_s && !modrst_s
      |=> state == ST_AWAIT_KEYWORD && port_owned_o)
      else $error("design interrupt not taken");
   a_module_reset: assert property (
      modrst_s |=> state == ST_AWAIT_KEYWORD && !cfg_prog_n_o && own)
      else $error("module reset did not reset loader and fabric");
   a_prog_pulse: assert property (
      s_start_taken |=> !cfg_prog_n_o && !word_ready)
      else $error("fabric not cleared before load");
   a_led_done: assert property (
      done_s |=> config_indicator_led_o)
      else $error("indicator not following done");
   a_hold_guard: assert property (
      s_end_taken |=> state == ST_IDLE [*4])
      else $error("idle left during release holdoff");

   // Idle for two cycles: the receiver has seen the port go away
   sequence s_idle_settled;
      state == ST_IDLE ##1 state == ST_IDLE;
   endsequence

   // Fabric reset is pulled only while loading, never while awaiting
   a_drive_only_load: assert property (
      !fabric_reset_oe_n_o |-> state == ST_CONFIG)
      else $error("fabric reset pulled outside loading");
   a_await_released: assert property (
      state == ST_AWAIT_KEYWORD |-> fabric_reset_oe_n_o && !cp_rdy_oe_n_o)
      else $error("awaiting without owning the port");
   a_load_ignores_irq: assert property (
      s_loading ##0 (fab_rst_low_s && !(word_take && word == END_KEY))
      |=> state == ST_CONFIG)
      else $error("loading left on fabric reset low");

   // Once idle, no byte is acknowledged and the fabric keeps its image
   a_idle_no_ack: assert property (
      s_idle_settled |-> cp_rdy_n_o && !word_take)
      else $error("byte acknowledged while idle");
   a_idle_fabric_kept: assert property (
      state == ST_IDLE |-> cfg_prog_n_o)
      else $error("fabric cleared while idle");
   a_hold_count: assert property (
      state == ST_IDLE && hold_cnt != '0 && !modrst_s |=> state == ST_IDLE)
      else $error("holdoff cut short");

   // Clear pulse ends exactly when the counter runs out
   a_prog_release: assert property (
      s_loading ##0 (prog_cnt == CNT_W'(1)) |=> cfg_prog_n_o)
      else $error("fabric clear not released");
   a_led_off: assert property (
      !done_s |=> !config_indicator_led_o)
      else $error("indicator on without done");
   a_cfg_held: assert property (
      cfg_valid_o && !cfg_ready_i && !modrst_s |=> cfg_valid_o && $stable(cfg_data_o))
      else $error("fabric word changed while stalled");
   a_await_no_data: assert property (
      s_awaiting ##0 word_take |=> $stable(cfg_data_o))
      else $error("keyword reached the fabric data");

   // Module reset blocks the port and hands it back to us
   a_mreset_blocks: assert property (
      modrst_s |-> !word_take && !byte_bus.valid)
      else $error("bytes taken during module reset");
   a_mreset_pins: assert property (
      modrst_s |=> !cp_rdy_oe_n_o && fabric_reset_oe_n_o)
      else $error("module reset did not reclaim the port");
endmodule // fcl_loader

/* testbench/fcl_host_model.sv */
// Host processor side of comm port 3: sends bytes under strobe/ready.
// Assumes the ready line reads high whenever nobody drives it.
`timescale 1ns/100ps
module fcl_host_model (
   // Clock
   input wire logic clk_i,
   // Comm-port pins
   input wire logic rdy_n_i,
   output logic [fcl_pkg::BYTE_W-1:0] data_o,
   output logic strb_n_o
);
   import fcl_pkg::*;

   initial begin
      data_o = 8'hff;
      strb_n_o = 1'b1;
   end

   // Holds strobe and data until ready is seen low; slow stretches the hold
   task automatic send_byte(input logic [BYTE_W-1:0] b, input int slow, input int lim,
                            output logic ok);
      int n;
      ok = 1'b0;
      n = 0;
      @(posedge clk_i);
      data_o <= b;
      strb_n_o <= 1'b0;
      while (!ok && n < lim) begin
         @(posedge clk_i);
         n++;
         ok = (rdy_n_i === 1'b0);
      end
      repeat (slow) @(posedge clk_i);
      strb_n_o <= 1'b1;
      // A released data bus must not keep showing the old byte
      data_o <= ~b;
      n = 0;
      while (ok && n < lim) begin
         @(posedge clk_i);
         n++;
         if (rdy_n_i === 1'b1)
            break;
      end
      if (n >= lim)
         ok = 1'b0;
   endtask
endmodule // fcl_host_model

/* testbench/tb_fabric_config_loader.sv */
// Self-checking bench of the configuration loader.
// Assumes pull-ups on the ready line and on the fabric reset wire.
`timescale 1ns/100ps
module tb_fabric_config_loader;
   import fcl_pkg::*;
   localparam int unsigned PROG_CYC = 4;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic mrst_n = 1'b1;
   logic [BYTE_W-1:0] cp_data;
   logic cp_strb_n;
   logic cp_rdy_n;
   logic cp_rdy_oe_n;
   logic port_owned;
   logic fab_rst_n_o;
   logic fab_rst_oe_n;
   logic fab_pull_n = 1'b1;
   logic prog_n;
   logic cfg_valid;
   logic cfg_ready = 1'b1;
   logic cfg_done = 1'b0;
   logic led;
   logic [WORD_W-1:0] cfg_data;
   logic [WORD_W-1:0] got_q[$];
   int n_errors = 0;
   int tests_run = 0;
   int low_run = 0;
   int last_low = 0;
   wire rdy_wire = cp_rdy_oe_n ? 1'b1 : cp_rdy_n;
   wire fab_wire = (fab_rst_oe_n ? 1'b1 : fab_rst_n_o) & fab_pull_n;

   always #4 clk = ~clk;

   // Fabric side: collects accepted words and measures clear pulses
   always @(posedge clk) begin
      if (cfg_valid === 1'b1 && cfg_ready === 1'b1)
         got_q.push_back(cfg_data);
      if (prog_n === 1'b0)
         low_run++;
      else if (low_run != 0) begin
         last_low = low_run;
         low_run = 0;
      end
   end

   fcl_host_model host (
      .clk_i(clk), .rdy_n_i(rdy_wire), .data_o(cp_data), .strb_n_o(cp_strb_n)
   );

   fcl_loader #(.PROG_CYC(PROG_CYC)) DUT (
      .clk_i(clk), .arst_n_i(arst_n), .ce_i(1'b1), .module_wide_reset_n_i(mrst_n),
      .cp_data_i(cp_data), .cp_strb_n_i(cp_strb_n), .cp_rdy_n_o(cp_rdy_n),
      .cp_rdy_oe_n_o(cp_rdy_oe_n), .port_owned_o(port_owned),
      .fabric_reset_n_i(fab_wire), .fabric_reset_n_o(fab_rst_n_o),
      .fabric_reset_oe_n_o(fab_rst_oe_n), .cfg_prog_n_o(prog_n), .cfg_data_o(cfg_data),
      .cfg_valid_o(cfg_valid), .cfg_ready_i(cfg_ready), .cfg_done_i(cfg_done),
      .config_indicator_led_o(led)
   );

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic send_word(input logic [WORD_W-1:0] w, input int slow);
      logic ok;
      for (int i = 0; i < BYTES_PER_WORD; i++) begin
         host.send_byte(w[i*BYTE_W +: BYTE_W], slow, 200, ok);
         chk(32'(ok), 32'h1, "byte acknowledged");
      end
      repeat (3) @(posedge clk);
   endtask

   task automatic pull_fabric_reset;
      @(posedge clk);
      fab_pull_n <= 1'b0;
      repeat (4) @(posedge clk);
      fab_pull_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic t_poll;
      send_word(32'h1234_5678, 0);
      send_word(32'hbcbc_bcbd, 2);
      chk(32'(fab_rst_oe_n), 32'h1, "no load on junk");
      chk(32'(prog_n), 32'h1, "fabric untouched");
      chk(32'(got_q.size()), 32'h0, "junk dropped");
      $display("test poll finished");
   endtask

   task automatic t_load;
      send_word(START_KEY, 0);
      chk(32'(fab_wire), 32'h0, "fabric held in reset");
      cfg_ready <= 1'b0;
      send_word(32'ha5c3_1e7f, 1);
      repeat (10) @(posedge clk);
      chk(32'(last_low), PROG_CYC, "clear pulse length");
      chk(32'(cfg_valid), 32'h1, "word held while stalled");
      chk(cfg_data, 32'ha5c3_1e7f, "byte order");
      cfg_ready <= 1'b1;
      send_word(32'h0102_0304, 0);
      chk(32'(fab_wire), 32'h0, "reset held to end");
      send_word(END_KEY, 0);
      chk(32'(got_q.size()), 32'h2, "word count");
      chk(got_q[1], 32'h0102_0304, "second word");
      chk(32'(port_owned), 32'h0, "port released");
      chk(32'(cp_rdy_oe_n), 32'h1, "ready pin released");
      chk(32'(fab_wire), 32'h1, "fabric reset released");
      cfg_done <= 1'b1;
      repeat (2) @(posedge clk);
      chk(32'(led), 32'h0, "indicator not early");
      repeat (2) @(posedge clk);
      chk(32'(led), 32'h1, "indicator on");
      $display("test load finished");
   endtask

   task automatic t_idle;
      logic ok;
      host.send_byte(8'hbc, 0, 20, ok);
      chk(32'(ok), 32'h0, "idle refuses bytes");
      pull_fabric_reset();
      chk(32'(port_owned), 32'h1, "interrupt regains port");
      send_word(END_KEY, 0);
      chk(32'(port_owned), 32'h0, "end word idles");
      chk(32'(prog_n), 32'h1, "fabric kept");
      repeat (6) @(posedge clk);
      pull_fabric_reset();
      last_low = 0;
      send_word(START_KEY, 0);
      chk(32'(fab_rst_oe_n), 32'h0, "start word reloads");
      chk(32'(last_low), PROG_CYC, "fabric cleared");
      $display("test interrupt finished");
   endtask

   task automatic t_mreset;
      logic ok;
      host.send_byte(8'h11, 0, 200, ok);
      @(posedge clk);
      mrst_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'(prog_n), 32'h0, "fabric reset");
      chk(32'(port_owned), 32'h1, "port owned");
      mrst_n <= 1'b1;
      repeat (3) @(posedge clk);
      send_word(END_KEY, 0);
      chk(32'(port_owned), 32'h0, "end after reset");
      chk(32'(got_q.size()), 32'h2, "partial word dropped");
      mrst_n <= 1'b0;
      repeat (4) @(posedge clk);
      mrst_n <= 1'b1;
      repeat (3) @(posedge clk);
      send_word(START_KEY, 0);
      send_word(32'h5a5a_0f0f, 0);
      chk(got_q[got_q.size()-1], 32'h5a5a_0f0f, "reload word");
      $display("test module reset finished");
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      t_poll();
      t_load();
      t_idle();
      t_mreset();
      complete_run();
   end

   // The whole run needs a few hundred cycles
   initial begin
      repeat (60000) @(posedge clk);
      n_errors++;
      complete_run();
   end
endmodule // tb_fabric_config_loader
